// ### uas_defines.svh
// Purpose: Register indexes, field positions, reset values and bit timing of the serial channel.
// Assumes: Byte address of a register is four times its index.
// Notes:   Definitions only; included by the package user.
`ifndef UAS_DEFINES_SVH
`define UAS_DEFINES_SVH

// Register indexes; the byte address is the index times four.
`define UAS_IDX_MODE      8'h70
`define UAS_IDX_STATUS    8'h71
`define UAS_IDX_SYNC      8'h72
`define UAS_IDX_BAUD      8'h73
`define UAS_IDX_TXSHIFT   8'h74
`define UAS_IDX_RXBUF     8'h75

// Reset values.
`define UAS_RST_MODE      8'h00
`define UAS_RST_BAUD      4'h0
`define UAS_RST_TXSHIFT   8'hff
`define UAS_RST_RXBUF     8'h00

// Parity field encodings of the mode register.
`define UAS_PAR_NONE      2'h0
`define UAS_PAR_ZERO      2'h1
`define UAS_PAR_ODD       2'h2
`define UAS_PAR_EVEN      2'h3

// Baud source select value that picks the external baud clock pin.
`define UAS_BAUD_EXT      4'h8
// Internal divider exponent is select plus this offset.
`define UAS_DIV_OFFSET    4'h2

// Sub-bit ticks: eight per bit, resample after four.
`define UAS_TICK_LAST     3'h7
`define UAS_TICK_HALF     3'h3

// Last data bit index for 7-bit and 8-bit characters.
`define UAS_LAST_BIT7     3'h6
`define UAS_LAST_BIT8     3'h7

// First-bit-order bit position in the sync mode register.
`define UAS_SYNC_DIR_BIT  2

`endif

// ### uas_pkg.sv
// Purpose: Types shared by the serial channel.
// Assumes: Constants live in uas_defines.svh.
// Notes:   Field order of the mode type matches the mode register bits 7 to 0.
package uas_pkg;

    // Frame phase, used by both transmitter and receiver.
    typedef enum logic [2:0] {
        UAS_IDLE,
        UAS_START,
        UAS_DATA,
        UAS_PARITY,
        UAS_STOP,
        UAS_DONE
    } uas_phase_type;

    // Mode register layout.
    typedef struct packed {
        logic       txEnable;
        logic       rxEnable;
        logic [1:0] parity;
        logic       charLen8;
        logic       stopTwo;
        logic [1:0] reserved;
    } uas_mode_type;

    // Receive error flags, bits 2 to 0 of the status register.
    typedef struct packed {
        logic parityErr;
        logic frameErr;
        logic overrun;
    } uas_error_type;

endpackage

// ### uas_uart.sv
// Purpose: Asynchronous serial transmitter and receiver with Avalon-MM registers.
// Assumes: All inputs synchronous to mclk; one register per aligned 32-bit word.
// Notes:   Rules follow.
// Contract
// - External source: bit rate is the external baud pin frequency over 16.
// - Frame: start, 7 or 8 data, optional parity, one or two stops.
// - 7-bit mode ignores transmit bit 7, receive bit 7 reads zero.
// - Even parity: ones count even on send; odd count flags error.
// - Odd parity: ones count odd on send; even count flags error.
// - Zero parity: send 0, never check, never flag error.
// - No parity: no parity bit sent or expected, no error.
// - Writing the transmit shift register starts a frame with framing bits added.
// - Transmit-done event when the shift register has emptied.
// - Receive input sampled only while receive enable is set, on chosen clock.
// - Low input starts half-bit count, resample; still low means start bit.
// - Frame ends after data, parity if any, and one checked stop bit.
// - Frame end copies data to buffer and signals receive-done, errors too.
// - Clearing receive enable halts at once; buffer, status, event untouched.
// - Status reads 04h parity, 02h framing, 01h overrun.
// - Buffer read clears errors; next frame also clears then sets its own.
// - Late receive disable: keep old data, update silently, or update and signal.
// - Source select 1000 picks the external baud pin.
// - Internal rate is mclk over two to the n plus one, times 8; the divider uses two to the n plus two, times 8.
`timescale 1ns/1ps

module uas_uart
    import uas_pkg::*;
(
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic [9:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    output logic      [31:0] readdata,
    output logic             waitrequest,
    input  wire logic        extBaudClockPin,
    input  wire logic        serialRxInput,
    output logic             serialTxOutput,
    output logic             txDoneIrq,
    output logic             rxDoneIrq
);
`include "uas_defines.svh"
    ////////////////////////////////////////////////////////////////////////////
    // Register bus slave.
    logic          busWait_reg;
    logic [31:0]   readData_reg;
    logic [31:0]   readValue;
    logic [7:0]    regIndex;
    logic          busDone;
    logic          wrStrobe;
    logic          rxRead;
    logic          txLoad;
    uas_mode_type  uartMode_reg;
    logic [3:0]    baudSelect_reg;
    logic          firstBitOrder_reg;
    logic [7:0]    txShift_reg;
    logic [7:0]    rxBuffer_reg;
    uas_error_type rxErrorStatus_reg;
    uas_phase_type txPhase_reg;
    assign regIndex    = address[9:2];
    assign busDone     = (read | write) & ~busWait_reg;
    assign wrStrobe    = write & ~busWait_reg & byteenable[0];
    assign rxRead      = read & ~busWait_reg & (regIndex == `UAS_IDX_RXBUF);
    assign txLoad      = wrStrobe & (regIndex == `UAS_IDX_TXSHIFT);
    assign readdata    = readData_reg;
    assign waitrequest = busWait_reg;
    // One wait cycle per access; the write acts when waitrequest is seen low.
    always_ff @(posedge mclk) begin
        if (rst) begin
            busWait_reg <= 1'b1;
        end else begin
            busWait_reg <= ~((read | write) & busWait_reg);
        end
    end
    // Read data is latched while waitrequest is high and held for one cycle.
    always_ff @(posedge mclk) begin
        if (rst) begin
            readData_reg <= 32'h0;
        end else if ((read & busWait_reg) == 1'b1) begin
            readData_reg <= readValue;
        end else if (busDone) begin
            readData_reg <= 32'h0;
        end
    end
    // Read decode; unmapped words read as zero.
    always_comb begin
        readValue = 32'h0;
        if (regIndex == `UAS_IDX_MODE) begin
            readValue[7:0] = uartMode_reg;
        end else if (regIndex == `UAS_IDX_STATUS) begin
            readValue[2:0] = rxErrorStatus_reg;
        end else if (regIndex == `UAS_IDX_SYNC) begin
            readValue[`UAS_SYNC_DIR_BIT] = firstBitOrder_reg;
        end else if (regIndex == `UAS_IDX_BAUD) begin
            readValue[7:4] = baudSelect_reg;
        end else if (regIndex == `UAS_IDX_TXSHIFT) begin
            readValue[7:0] = txShift_reg;
        end else if (regIndex == `UAS_IDX_RXBUF) begin
            readValue[7:0] = rxBuffer_reg;
        end
    end
    // Configuration registers; reserved mode bits always hold zero.
    always_ff @(posedge mclk) begin
        if (rst) begin
            uartMode_reg      <= uas_mode_type'(`UAS_RST_MODE);
            baudSelect_reg    <= `UAS_RST_BAUD;
            firstBitOrder_reg <= 1'b0;
        end else if (wrStrobe) begin
            if (regIndex == `UAS_IDX_MODE) begin
                uartMode_reg <= uas_mode_type'({writedata[7:2], 2'h0});
            end else if (regIndex == `UAS_IDX_BAUD) begin
                baudSelect_reg <= writedata[7:4];
            end else if (regIndex == `UAS_IDX_SYNC) begin
                firstBitOrder_reg <= writedata[`UAS_SYNC_DIR_BIT];
            end
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Sub-bit tick generation, eight ticks per bit.
    logic [9:0] divCount_reg;
    logic [9:0] divMask;
    logic       extPrev_reg;
    logic       extHalf_reg;
    logic       extRise;
    logic       extSelect;
    logic       subTick;
    assign extSelect = (baudSelect_reg == `UAS_BAUD_EXT);
    assign divMask   = ~(10'h3ff << ({1'b0, baudSelect_reg[2:0]} + `UAS_DIV_OFFSET));
    assign extRise   = extBaudClockPin & ~extPrev_reg;
    // Every second rising pin edge is a tick, so a bit is sixteen pin periods.
    assign subTick   = extSelect ? (extRise & extHalf_reg)
                                 : ((divCount_reg & divMask) == divMask);
    // Free-running divider; writing the select mid-frame disturbs timing.
    always_ff @(posedge mclk) begin
        if (rst) begin
            divCount_reg <= 10'h0;
        end else begin
            divCount_reg <= divCount_reg + 10'h1;
        end
    end
    // Edge detector and halver on the external baud pin.
    always_ff @(posedge mclk) begin
        if (rst) begin
            extPrev_reg <= 1'b0;
            extHalf_reg <= 1'b0;
        end else begin
            extPrev_reg <= extBaudClockPin;
            extHalf_reg <= extHalf_reg ^ extRise;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    // Transmitter.
    logic [7:0] txData;
    logic [7:0] txBits_reg;
    logic [2:0] txTick_reg;
    logic [2:0] txIndex_reg;
    logic [2:0] txLastBit;
    logic       txParity_reg;
    logic       txSecondStop_reg;
    logic       txOut_reg;
    logic       txDone_reg;
    logic       txBitEnd;
    assign txData         = uartMode_reg.charLen8 ? writedata[7:0]
                                                  : {1'b0, writedata[6:0]};
    assign txLastBit      = uartMode_reg.charLen8 ? `UAS_LAST_BIT8 : `UAS_LAST_BIT7;
    assign txBitEnd       = subTick && txTick_reg == `UAS_TICK_LAST;
    assign serialTxOutput = txOut_reg;
    assign txDoneIrq      = txDone_reg;
    // Shift register is loaded only when idle so a frame in flight is not corrupted.
    always_ff @(posedge mclk) begin
        if (rst) begin
            txShift_reg <= `UAS_RST_TXSHIFT;
        end else if (txLoad && txPhase_reg == UAS_IDLE) begin
            txShift_reg <= txData;
        end
    end
    // Frame sequencer; clearing transmit enable aborts to idle with the line high.
    always_ff @(posedge mclk) begin
        if (rst) begin
            txPhase_reg      <= UAS_IDLE;
            txTick_reg       <= 3'h0;
            txIndex_reg      <= 3'h0;
            txBits_reg       <= 8'h0;
            txParity_reg     <= 1'b0;
            txSecondStop_reg <= 1'b0;
            txOut_reg        <= 1'b1;
            txDone_reg       <= 1'b0;
        end else if (!uartMode_reg.txEnable) begin
            txPhase_reg <= UAS_IDLE;
            txOut_reg   <= 1'b1;
            txDone_reg  <= 1'b0;
        end else begin
            txDone_reg <= 1'b0;
            txTick_reg <= txTick_reg + {2'h0, subTick};
            case (txPhase_reg)
                UAS_IDLE: begin
                    if (txLoad) begin
                        txPhase_reg <= UAS_START;
                        txBits_reg  <= txData;
                        txTick_reg  <= 3'h0;
                        txOut_reg   <= 1'b0;
                        txSecondStop_reg <= uartMode_reg.stopTwo;
                        case (uartMode_reg.parity)
                            `UAS_PAR_EVEN: txParity_reg <= ^txData;
                            `UAS_PAR_ODD:  txParity_reg <= ~^txData;
                            default:       txParity_reg <= 1'b0;
                        endcase
                    end
                end
                UAS_START: begin
                    if (txBitEnd) begin
                        txPhase_reg <= UAS_DATA;
                        txIndex_reg <= 3'h0;
                        txOut_reg   <= txBits_reg[0];
                    end
                end
                UAS_DATA: begin
                    if (txBitEnd) begin
                        txBits_reg  <= {1'b0, txBits_reg[7:1]};
                        txIndex_reg <= txIndex_reg + 3'h1;
                        if (txIndex_reg != txLastBit) begin
                            txOut_reg <= txBits_reg[1];
                        end else if (uartMode_reg.parity != `UAS_PAR_NONE) begin
                            txPhase_reg <= UAS_PARITY;
                            txOut_reg   <= txParity_reg;
                        end else begin
                            txPhase_reg <= UAS_STOP;
                            txOut_reg   <= 1'b1;
                        end
                    end
                end
                UAS_PARITY: begin
                    if (txBitEnd) begin
                        txPhase_reg <= UAS_STOP;
                        txOut_reg   <= 1'b1;
                    end
                end
                UAS_STOP: begin
                    if (txBitEnd) begin
                        if (txSecondStop_reg) begin
                            txSecondStop_reg <= 1'b0;
                        end else begin
                            txPhase_reg <= UAS_IDLE;
                            txDone_reg  <= 1'b1;
                        end
                    end
                end
                default: begin
                    txPhase_reg <= UAS_IDLE;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receiver.
    uas_phase_type rxPhase_reg;
    logic [7:0]    rxShift_reg;
    logic [7:0]    rxData;
    logic [2:0]    rxTick_reg;
    logic [2:0]    rxIndex_reg;
    logic          rxParityBit_reg;
    logic          rxParityBad;
    logic          rxCapture;
    logic          rxUnread_reg;
    logic          rxDone_reg;
    logic          rxBitEnd;
    assign rxData    = uartMode_reg.charLen8 ? rxShift_reg
                                             : {1'b0, rxShift_reg[7:1]};
    assign rxBitEnd  = subTick && rxTick_reg == `UAS_TICK_LAST;
    assign rxCapture = uartMode_reg.rxEnable && rxPhase_reg == UAS_STOP && rxBitEnd;
    assign rxDoneIrq = rxDone_reg;
    // Parity check; zero and no-parity modes never flag.
    always_comb begin
        case (uartMode_reg.parity)
            `UAS_PAR_EVEN: rxParityBad = ^{rxData, rxParityBit_reg};
            `UAS_PAR_ODD:  rxParityBad = ~^{rxData, rxParityBit_reg};
            default:       rxParityBad = 1'b0;
        endcase
    end
    // Frame sequencer; clearing receive enable drops straight back to idle.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rxPhase_reg     <= UAS_IDLE;
            rxShift_reg     <= 8'h0;
            rxTick_reg      <= 3'h0;
            rxIndex_reg     <= 3'h0;
            rxParityBit_reg <= 1'b0;
        end else if (!uartMode_reg.rxEnable) begin
            rxPhase_reg <= UAS_IDLE;
        end else begin
            rxTick_reg <= rxTick_reg + {2'h0, subTick};
            case (rxPhase_reg)
                UAS_IDLE: begin
                    if (subTick && !serialRxInput) begin
                        rxPhase_reg <= UAS_START;
                        rxTick_reg  <= 3'h0;
                    end
                end
                UAS_START: begin
                    if (subTick && rxTick_reg == `UAS_TICK_HALF) begin
                        rxTick_reg  <= 3'h0;
                        rxIndex_reg <= 3'h0;
                        rxPhase_reg <= serialRxInput ? UAS_IDLE : UAS_DATA;
                    end
                end
                UAS_DATA: begin
                    if (rxBitEnd) begin
                        rxShift_reg <= {serialRxInput, rxShift_reg[7:1]};
                        rxIndex_reg <= rxIndex_reg + 3'h1;
                        if (rxIndex_reg == txLastBit) begin
                            rxPhase_reg <= (uartMode_reg.parity == `UAS_PAR_NONE)
                                           ? UAS_STOP : UAS_PARITY;
                        end
                    end
                end
                UAS_PARITY: begin
                    if (rxBitEnd) begin
                        rxParityBit_reg <= serialRxInput;
                        rxPhase_reg     <= UAS_STOP;
                    end
                end
                UAS_STOP: begin
                    if (rxBitEnd) begin
                        rxPhase_reg <= UAS_DONE;
                    end
                end
                default: begin
                    rxPhase_reg <= UAS_IDLE;
                end
            endcase
        end
    end
    // Receive-done pulse one cycle after the buffer update, if still enabled.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rxDone_reg <= 1'b0;
        end else begin
            rxDone_reg <= uartMode_reg.rxEnable && rxPhase_reg == UAS_DONE;
        end
    end
    // Buffer and error status; a completing frame wins over a same-cycle read.
    always_ff @(posedge mclk) begin
        if (rst) begin
            rxBuffer_reg      <= `UAS_RST_RXBUF;
            rxErrorStatus_reg <= '0;
            rxUnread_reg      <= 1'b0;
        end else if (rxCapture) begin
            rxBuffer_reg                <= rxData;
            rxErrorStatus_reg.parityErr <= rxParityBad;
            rxErrorStatus_reg.frameErr  <= ~serialRxInput;
            rxErrorStatus_reg.overrun   <= rxUnread_reg & ~rxRead;
            rxUnread_reg                <= 1'b1;
        end else if (rxRead) begin
            rxErrorStatus_reg <= '0;
            rxUnread_reg      <= 1'b0;
        end
    end
endmodule

// ### uas_uart_monitor.sv
// Purpose: Port-level checks of the serial channel.
// Assumes: Register indexes from uas_defines.svh.
// Notes:   Mirrors mode and transmit busy from bus writes.
`timescale 1ns/1ps
`include "uas_defines.svh"
module uas_uart_monitor
    import uas_pkg::*;
(
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic [9:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    input wire logic        serialTxOutput,
    input wire logic        txDoneIrq,
    input wire logic        rxDoneIrq
);
    logic [7:0] modeReg;
    logic       txBusy;
    logic       wrDone;
    logic       modeWr;
    logic       txGo;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    ////////////////////////////////////////////////////////////////////////////
    // Completed writes and a transmit start as seen at the ports.
    assign wrDone = write && !waitrequest && byteenable[0];
    assign modeWr = wrDone && address[9:2] == `UAS_IDX_MODE;
    assign txGo   = wrDone && address[9:2] == `UAS_IDX_TXSHIFT && modeReg[7] && !txBusy;
    // Mode byte as last written.
    always_ff @(posedge mclk) begin
        if (rst) modeReg <= 8'h00;
        else if (modeWr) modeReg <= writedata[7:0];
    end
    // Busy from a start until the done pulse or a transmit disable.
    always_ff @(posedge mclk) begin
        if (rst) txBusy <= 1'b0;
        else if (txGo) txBusy <= 1'b1;
        else if (txDoneIrq || (modeWr && !writedata[7])) txBusy <= 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    sequence busTaken;
        (read || write) && waitrequest;
    endsequence
    sequence answerPulse;
        !waitrequest ##1 waitrequest;
    endsequence
    sequence rxOffLong;
        !modeReg[6] [*3];
    endsequence
    sequence txQuiet;
        !txBusy [*2];
    endsequence
    AST_BUS_ANSWER: assert property (busTaken |=> answerPulse)
        else $error("Bus answer is not a single cycle.");
    AST_UPPER_ZERO: assert property (!waitrequest |-> readdata[31:8] == 24'h0)
        else $error("Upper read bits are not zero.");
    AST_STATUS_BITS: assert property (read && !waitrequest &&
        address[9:2] == `UAS_IDX_STATUS |-> readdata[7:3] == 5'h0)
        else $error("Unused status bits are set.");
    AST_RX_BIT7: assert property (read && !waitrequest && !modeReg[3] &&
        address[9:2] == `UAS_IDX_RXBUF |-> !readdata[7])
        else $error("Seven-bit data returned bit 7 set.");
    AST_TX_START: assert property (txGo |=> !serialTxOutput)
        else $error("Start bit missing after transmit write.");
    AST_TX_IDLE_HIGH: assert property (txQuiet |-> serialTxOutput)
        else $error("Transmit line low while idle.");
    AST_TX_DONE_HIGH: assert property (txDoneIrq |-> txBusy && serialTxOutput)
        else $error("Transmit done without a finished frame.");
    AST_TX_PULSE: assert property (txDoneIrq |=> !txDoneIrq)
        else $error("Transmit done longer than one cycle.");
    AST_RX_OFF_QUIET: assert property (rxOffLong |-> !rxDoneIrq)
        else $error("Receive done while reception is off.");
endmodule
bind uas_uart uas_uart_monitor u_uas_uart_monitor (.mclk, .rst, .address, .read, .write,
    .writedata, .byteenable, .readdata, .waitrequest, .serialTxOutput, .txDoneIrq, .rxDoneIrq);

// ### uas_remote_model.sv
// Purpose: Remote serial device on the channel's line pins.
// Assumes: Idle line high; bit length given in mclk cycles.
// Notes:   Keeps eleven mid-bit samples per frame.
`timescale 1ns/1ps
module uas_remote_model (
    input wire logic        mclk,
    input wire logic        txLine,
    output logic            rxLine,
    input wire logic [31:0] bitCycles
);
    logic [10:0] frames[$];
    logic [10:0] sampled;
    initial rxLine = 1'b1;
    // Sends a start bit, the given bits first bit first, then one idle bit.
    task automatic sendFrame(input logic [10:0] bits, input int nbits);
        rxLine <= 1'b0;
        repeat (bitCycles) @(posedge mclk);
        for (int i = 0; i < nbits; i++) begin
            rxLine <= bits[i];
            repeat (bitCycles) @(posedge mclk);
        end
        rxLine <= 1'b1;
        repeat (bitCycles) @(posedge mclk);
    endtask
    // Samples the transmit line near mid-bit after each falling edge.
    initial begin
        forever begin
            @(negedge txLine);
            repeat (bitCycles / 2 + 4) @(posedge mclk);
            for (int i = 0; i < 11; i++) begin
                repeat (bitCycles) @(posedge mclk);
                sampled[i] = txLine;
            end
            frames.push_back(sampled);
        end
    end
endmodule

// ### test_uart_async_serial_channel.sv
// Purpose: Self-checking bench for the serial channel.
// Assumes: Remote model on the line pins; byte lane 0 always enabled.
// Notes:   Expected frames and status come from a bench model.
`timescale 1ns/1ps
`include "uas_defines.svh"
module test_uart_async_serial_channel
    import uas_pkg::*;
;
    logic        mclk, rst, read, write, waitrequest, serialRxInput, serialTxOutput;
    logic        txDoneIrq, rxDoneIrq, c8, unread;
    logic [9:0]  address;
    logic [1:0]  extDiv;
    logic [2:0]  st;
    logic [7:0]  rnd;
    logic [10:0] f;
    logic [31:0] writedata, readdata, q, lastData, bitCycles, txIrqCnt, rxIrqCnt, txExp, rxExp;
    int          error_cnt, checks_done, n;
    logic [7:0]  resetVals [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00, 8'h00};
    logic [7:0]  baudVals [3] = '{8'h00, 8'h10, 8'h80};
    logic [31:0] bitVals [3] = '{32'd32, 32'd64, 32'd64};
    uas_uart u_uas_uart (.mclk, .rst, .address, .read, .write, .writedata, .byteenable(4'h1),
        .readdata, .waitrequest, .extBaudClockPin(extDiv[1]), .serialRxInput, .serialTxOutput,
        .txDoneIrq, .rxDoneIrq);
    uas_remote_model u_far (.mclk, .txLine(serialTxOutput), .rxLine(serialRxInput), .bitCycles);
    ////////////////////////////////////////////////////////////////////////////
    // Clock, external baud pin at a quarter of it, and done pulse counters.
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        extDiv <= extDiv + 2'h1;
        txIrqCnt <= txIrqCnt + 32'(txDoneIrq === 1'b1);
        rxIrqCnt <= rxIrqCnt + 32'(rxDoneIrq === 1'b1);
    end
    function automatic logic [7:0] lfsr(logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Line bits after the start bit, idle ones beyond the stop bit.
    function automatic logic [10:0] frameOf(logic [7:0] d, logic [1:0] p, logic w8);
        logic [10:0] g;
        logic        odd;
        g = 11'h7ff;
        odd = ^(d & (w8 ? 8'hff : 8'h7f));
        for (int i = 0; i < (w8 ? 8 : 7); i++) g[i] = d[i];
        if (p == `UAS_PAR_EVEN) g[w8 ? 8 : 7] = odd;
        if (p == `UAS_PAR_ODD) g[w8 ? 8 : 7] = !odd;
        if (p == `UAS_PAR_ZERO) g[w8 ? 8 : 7] = 1'b0;
        return g;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // One Avalon access, held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] r);
        int k;
        k = 0;
        address <= {idx, 2'b00};
        writedata <= {24'h0, d};
        read <= !wr;
        write <= wr;
        @(posedge mclk);
        while (waitrequest !== 1'b0 && k < 50) begin
            k++;
            @(posedge mclk);
        end
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (k == 50) error_cnt++;
        @(posedge mclk);
    endtask
    task automatic tally_and_finish;
        $display("Checks %0d, errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // Watchdog against a hung handshake or frame.
    initial begin
        repeat (60000) @(posedge mclk);
        error_cnt++;
        tally_and_finish();
    end
    ////////////////////////////////////////////////////////////////////////////
    // Reset values, frames in every parity mode at source selects 0 and 1 and the external pin, then halt.
    initial begin
        {rst, read, write, address, writedata, extDiv} = {1'b1, 46'h0};
        {txIrqCnt, rxIrqCnt, txExp, rxExp, unread, rnd} = {129'h0, 8'h0c};
        bitCycles = 32'd32;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        for (int i = 0; i < 7; i++) begin
            bus(1'b0, 8'h70 + 8'(i), 8'h00, q);
            check(q, {24'h0, resetVals[i]});
        end
        for (int c = 0; c < 3; c++) begin
            bitCycles = bitVals[c];
            bus(1'b1, `UAS_IDX_BAUD, baudVals[c], q);
            for (int p = 0; p < 4; p++) begin
                rnd = lfsr(rnd);
                c8 = rnd[0];
                bus(1'b1, `UAS_IDX_MODE, {2'b11, 2'(p), c8, rnd[1], 2'b00}, q);
                bus(1'b1, `UAS_IDX_TXSHIFT, rnd, q);
                repeat (13 * bitCycles) @(posedge mclk);
                txExp++;
                check(txIrqCnt, txExp);
                check(32'(u_far.frames.size()), 32'h1);
                if (u_far.frames.size() > 0) check(32'(u_far.frames.pop_front()),
                    32'(frameOf(rnd, 2'(p), c8)));
                rnd = lfsr(rnd);
                f = frameOf(rnd, 2'(p), c8);
                n = (c8 ? 8 : 7) + 32'(p != 0);
                if (rnd[2] && p != 0) f[n - 1] = !f[n - 1];
                if (rnd[3]) f[n] = 1'b0;
                st = {rnd[2] && p > 1, rnd[3], unread};
                u_far.sendFrame(f, n + 1);
                unread = 1'b1;
                rxExp++;
                check(rxIrqCnt, rxExp);
                if (p != 1) begin
                    bus(1'b0, `UAS_IDX_STATUS, 8'h00, q);
                    check(q, {29'h0, st});
                    bus(1'b0, `UAS_IDX_RXBUF, 8'h00, q);
                    check(q, {24'h0, c8 & rnd[7], rnd[6:0]});
                    lastData = q;
                    bus(1'b0, `UAS_IDX_STATUS, 8'h00, q);
                    check(q, 32'h0);
                    unread = 1'b0;
                end
            end
        end
        bus(1'b1, `UAS_IDX_MODE, 8'h48, q);
        fork
            u_far.sendFrame(11'h7aa, 9);
            begin
                repeat (5 * bitCycles) @(posedge mclk);
                bus(1'b1, `UAS_IDX_MODE, 8'h08, q);
            end
        join
        check(rxIrqCnt, rxExp);
        bus(1'b0, `UAS_IDX_RXBUF, 8'h00, q);
        check(q, lastData);
        bus(1'b1, `UAS_IDX_TXSHIFT, 8'hff, q);
        repeat (13 * bitCycles) @(posedge mclk);
        check(32'(u_far.frames.size()), 32'h0);
        tally_and_finish();
    end
endmodule
